// file: pkg/timer_pkg.sv
// package: register map, field layout and modes of the 16-bit timer block
`default_nettype none
package timer_pkg;
   localparam logic [15:0] ADDR_MODE_CTRL = 16'hFF60;
   localparam logic [15:0] ADDR_CMP_FIRST = 16'hFF64;
   localparam logic [15:0] ADDR_CMP_SECOND = 16'hFF68;
   localparam logic [15:0] ADDR_COUNTER   = 16'hFF6C;
   localparam logic [15:0] ADDR_CC_CTRL   = 16'hFF70;
   localparam logic [15:0] ADDR_PRESCALER = 16'hFF74;
   localparam logic [15:0] ADDR_IRQ_STAT  = 16'hFF78;
   localparam logic [15:0] ADDR_IRQ_MASK  = 16'hFF7C;
   // timer_mode_control fields
   localparam int BIT_OVERFLOW   = 0;
   localparam int BIT_OUT_TIMING = 1;
   localparam int BIT_OP_LO      = 2;
   localparam int BIT_OP_HI      = 3;
   // capture_compare_control and prescaler_mode fields
   localparam int BIT_SECOND_SEL = 2;
   localparam int BIT_EDGE_LO    = 4;
   localparam int BIT_EDGE_HI    = 5;
   localparam int BIT_CLK_LO     = 0;
   localparam int BIT_CLK_HI     = 1;
   // interrupt status bits
   localparam int IRQ_MATCH_FIRST  = 0;
   localparam int IRQ_MATCH_SECOND = 1;
   localparam int IRQ_OVERFLOW     = 2;
   localparam int IRQ_BITS         = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [IRQ_BITS-1:0] RST_IRQ = 3'h0;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   // count clock dividers: tick when the divider low bits are all ones
   localparam logic [5:0] DIV_MASK_2  = 6'h01;
   localparam logic [5:0] DIV_MASK_8  = 6'h07;
   localparam logic [5:0] DIV_MASK_64 = 6'h3F;
   typedef enum logic [3:0] {
      MODE_STOP      = 4'b0001,
      MODE_FREE      = 4'b0010,
      MODE_CLR_EDGE  = 4'b0100,
      MODE_CLR_MATCH = 4'b1000
   } mode_t;
   function automatic mode_t mode_decode(input logic [1:0] op);
      case (op)
         2'b01:   mode_decode = MODE_FREE;
         2'b10:   mode_decode = MODE_CLR_EDGE;
         2'b11:   mode_decode = MODE_CLR_MATCH;
         default: mode_decode = MODE_STOP;
      endcase
   endfunction : mode_decode
endpackage : timer_pkg
`default_nettype wire

// file: pkg/timer_link_if.sv
// interface: configuration and events between timer control, counter and edge detector
`timescale 1ns/1ps
`default_nettype none
interface timer_link_if;
   logic [1:0]  op_mode;
   logic [1:0]  edge_sel;
   logic        count_tick;
   logic        second_is_capture;
   logic [15:0] cmp_first;
   logic [15:0] cmp_second;
   logic        valid_edge;
   logic [15:0] count;
   logic        match_first;
   logic        match_second;
   logic        wrap;
   modport ctrl (output op_mode, edge_sel, count_tick, second_is_capture, cmp_first,
                 cmp_second, input valid_edge, count, match_first, match_second, wrap);
   modport core (input op_mode, count_tick, second_is_capture, cmp_first, cmp_second,
                 valid_edge, output count, match_first, match_second, wrap);
   modport edge_det (input edge_sel, output valid_edge);
endinterface : timer_link_if
`default_nettype wire

// file: core/input_edge_detect.sv
// valid edge detector for the first timer input pin
`timescale 1ns/1ps
`default_nettype none
module input_edge_detect
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // pin and link
   input  wire logic timer_input_first,
   timer_link_if.edge_det lnk
);
   logic prev_q;
   logic prev_d;
   logic rise;
   logic fall;
   always_comb begin
      prev_d = timer_input_first;
      rise   = timer_input_first & ~prev_q;
      fall   = ~timer_input_first & prev_q;
      case (lnk.edge_sel)
         2'b00:   lnk.valid_edge = fall;
         2'b01:   lnk.valid_edge = rise;
         2'b11:   lnk.valid_edge = rise | fall;
         default: lnk.valid_edge = 1'b0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end
endmodule : input_edge_detect
`default_nettype wire

// file: core/count_core.sv
// 16-bit up counter with clear modes and compare matches
`timescale 1ns/1ps
`default_nettype none
module count_core
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // link
   timer_link_if.core lnk
);
   mode_t       mode;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        adv_q;
   logic        adv_d;
   logic        wrap_q;
   logic        wrap_d;
   logic        run;
   always_comb begin
      mode   = mode_decode(lnk.op_mode);
      run    = (mode != MODE_STOP);
      cnt_d  = cnt_q;
      adv_d  = 1'b0;
      wrap_d = 1'b0;
      case (mode)
         MODE_STOP: begin
            cnt_d = 16'h0000;
         end
         MODE_CLR_EDGE: begin
            if (lnk.valid_edge) begin
               cnt_d = 16'h0000;
            end else if (lnk.count_tick) begin
               cnt_d  = cnt_q + 16'h0001;
               adv_d  = 1'b1;
               wrap_d = (cnt_q == COUNT_ALL_ONES);
            end
         end
         MODE_CLR_MATCH: begin
            if (lnk.count_tick) begin
               if (cnt_q == lnk.cmp_first) begin
                  cnt_d = 16'h0000;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
                  adv_d = 1'b1;
               end
               wrap_d = (cnt_q == COUNT_ALL_ONES);
            end
         end
         default: begin
            if (lnk.count_tick) begin
               cnt_d  = cnt_q + 16'h0001;
               adv_d  = 1'b1;
               wrap_d = (cnt_q == COUNT_ALL_ONES);
            end
         end
      endcase
      // matches only after an increment, so a zero compare fires after the wrap
      lnk.match_first  = run & adv_q & (cnt_q == lnk.cmp_first);
      lnk.match_second = run & adv_q & ~lnk.second_is_capture
                         & (cnt_q == lnk.cmp_second);
      lnk.count = cnt_q;
      lnk.wrap  = wrap_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 16'h0000;
         adv_q  <= 1'b0;
         wrap_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         adv_q  <= adv_d;
         wrap_q <= wrap_d;
      end
   end
endmodule : count_core
`default_nettype wire

// file: core/timer_mode_and_capture_ctrl.sv
// top: apb registers, capture, output toggle and interrupts of the 16-bit timer
//
// Function
// - capture mode: while running, load second register with counter on valid first-input edge.
// - second register written only as one 16-bit access; not cleared by reset.
// - zero compare in free-run or edge-clear mode matches right after wrap.
// - mode control resets to zero and accepts bit and byte writes.
// - counter runs whenever the operating-mode field is not 00.
// - mode 00 stops and clears counter; output kept, no interrupt.
// - mode 01 free-runs; output toggles on matches, plus edges if timing bit.
// - running: first match interrupt from first compare, second from second.
// - mode 10 clears and restarts counter on each valid first-input edge.
// - mode 11 clears and restarts on first compare match; toggles as before.
// - overflow flag set when counter rolls from all ones to zero.
// - edge select: 00 falling, 01 rising, 11 both, 10 none.
// - compare mode: second register compared continuously, match raises interrupt.
// - select bit: 0 makes second register compare, 1 capture; resets 0.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_and_capture_ctrl
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // timer pins
   input  wire logic        timer_input_first,
   output logic             timer_output_pin,
   // interrupts
   output logic             match_irq_first,
   output logic             match_irq_second,
   output logic             irq
);
   timer_link_if lnk ();

   // register state
   logic [3:1]          mode_q;
   logic [3:1]          mode_d;
   logic                ovf_q;
   logic                ovf_d;
   logic                sel_second_q;
   logic                sel_second_d;
   logic [1:0]          edge_sel_q;
   logic [1:0]          edge_sel_d;
   logic [1:0]          clk_sel_q;
   logic [1:0]          clk_sel_d;
   logic [15:0]         cmp_first_q;
   logic [15:0]         cmp_first_d;
   logic [15:0]         cmp_second_q;
   logic [15:0]         cmp_second_d;
   logic [IRQ_BITS-1:0] stat_q;
   logic [IRQ_BITS-1:0] stat_d;
   logic [IRQ_BITS-1:0] mask_q;
   logic [IRQ_BITS-1:0] mask_d;
   // bus answer state
   logic                pready_q;
   logic                pready_d;
   logic [31:0]         prdata_q;
   logic [31:0]         prdata_d;
   logic                pslverr_q;
   logic                pslverr_d;
   // timer side state
   logic [5:0]          div_q;
   logic [5:0]          div_d;
   logic                tout_q;
   logic                tout_d;
   logic                mirq1_q;
   logic                mirq1_d;
   logic                mirq2_q;
   logic                mirq2_d;
   logic                irq_q;
   logic                irq_d;
   // decode
   logic                hit_mode;
   logic                hit_cmp1;
   logic                hit_cmp2;
   logic                hit_cnt;
   logic                hit_ccc;
   logic                hit_pre;
   logic                hit_stat;
   logic                hit_mask;
   logic                mapped;
   logic                wr;
   logic                wr_byte;
   logic                wr_half;
   logic                running;
   logic                toggle;
   logic                capture;
   logic [IRQ_BITS-1:0] events;
   logic [31:0]         rd_val;

   // address decode
   always_comb begin
      hit_mode = 1'b0;
      hit_cmp1 = 1'b0;
      hit_cmp2 = 1'b0;
      hit_cnt  = 1'b0;
      hit_ccc  = 1'b0;
      hit_pre  = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      if (paddr == ADDR_MODE_CTRL) begin
         hit_mode = 1'b1;
      end else if (paddr == ADDR_CMP_FIRST) begin
         hit_cmp1 = 1'b1;
      end else if (paddr == ADDR_CMP_SECOND) begin
         hit_cmp2 = 1'b1;
      end else if (paddr == ADDR_COUNTER) begin
         hit_cnt = 1'b1;
      end else if (paddr == ADDR_CC_CTRL) begin
         hit_ccc = 1'b1;
      end else if (paddr == ADDR_PRESCALER) begin
         hit_pre = 1'b1;
      end else if (paddr == ADDR_IRQ_STAT) begin
         hit_stat = 1'b1;
      end else if (paddr == ADDR_IRQ_MASK) begin
         hit_mask = 1'b1;
      end
      mapped  = hit_mode | hit_cmp1 | hit_cmp2 | hit_cnt
                | hit_ccc | hit_pre | hit_stat | hit_mask;
      wr      = psel & penable & pready_q & pwrite & mapped;
      wr_byte = wr & pstrb[0];
      wr_half = wr & (pstrb[1:0] == 2'b11);
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_mode) begin
         rd_val[BIT_OP_HI:BIT_OUT_TIMING] = mode_q;
         rd_val[BIT_OVERFLOW]             = ovf_q;
      end else if (hit_cmp1) begin
         rd_val[15:0] = cmp_first_q;
      end else if (hit_cmp2) begin
         rd_val[15:0] = cmp_second_q;
      end else if (hit_cnt) begin
         rd_val[15:0] = lnk.count;
      end else if (hit_ccc) begin
         rd_val[BIT_SECOND_SEL] = sel_second_q;
      end else if (hit_pre) begin
         rd_val[BIT_EDGE_HI:BIT_EDGE_LO] = edge_sel_q;
         rd_val[BIT_CLK_HI:BIT_CLK_LO]   = clk_sel_q;
      end else if (hit_stat) begin
         rd_val[IRQ_BITS-1:0] = stat_q;
      end else if (hit_mask) begin
         rd_val[IRQ_BITS-1:0] = mask_q;
      end
   end

   // apb answer: one wait state, error on unmapped address
   always_comb begin
      pready_d  = psel & penable & ~pready_q;
      prdata_d  = pready_d ? rd_val : 32'h0000_0000;
      pslverr_d = pready_d & ~mapped;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // control registers
   always_comb begin
      mode_d       = mode_q;
      sel_second_d = sel_second_q;
      edge_sel_d   = edge_sel_q;
      clk_sel_d    = clk_sel_q;
      mask_d       = mask_q;
      if (wr_byte && hit_mode) begin
         mode_d = pwdata[BIT_OP_HI:BIT_OUT_TIMING];
      end
      if (wr_byte && hit_ccc) begin
         sel_second_d = pwdata[BIT_SECOND_SEL];
      end
      if (wr_byte && hit_pre) begin
         edge_sel_d = pwdata[BIT_EDGE_HI:BIT_EDGE_LO];
         clk_sel_d  = pwdata[BIT_CLK_HI:BIT_CLK_LO];
      end
      if (wr_byte && hit_mask) begin
         mask_d = pwdata[IRQ_BITS-1:0];
      end
      // hardware set wins; writing one keeps the flag, writing zero clears it
      ovf_d = lnk.wrap | ovf_q;
      if (wr_byte && hit_mode && !lnk.wrap) begin
         ovf_d = ovf_q & pwdata[BIT_OVERFLOW];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_d_reset : begin
            mode_q       <= RST_BYTE[BIT_OP_HI:BIT_OUT_TIMING];
            ovf_q        <= RST_BYTE[BIT_OVERFLOW];
            sel_second_q <= RST_BYTE[BIT_SECOND_SEL];
            edge_sel_q   <= RST_BYTE[BIT_EDGE_HI:BIT_EDGE_LO];
            clk_sel_q    <= RST_BYTE[BIT_CLK_HI:BIT_CLK_LO];
            mask_q       <= RST_IRQ;
         end
      end else begin
         mode_q       <= mode_d;
         ovf_q        <= ovf_d;
         sel_second_q <= sel_second_d;
         edge_sel_q   <= edge_sel_d;
         clk_sel_q    <= clk_sel_d;
         mask_q       <= mask_d;
      end
   end

   // compare / capture data: no reset, contents undefined after reset
   always_comb begin
      running      = (lnk.op_mode != 2'b00);
      capture      = running & sel_second_q & lnk.valid_edge;
      cmp_first_d  = cmp_first_q;
      cmp_second_d = cmp_second_q;
      if (wr_half && hit_cmp1) begin
         cmp_first_d = pwdata[15:0];
      end
      if (capture) begin
         cmp_second_d = lnk.count;
      end else if (wr_half && hit_cmp2) begin
         cmp_second_d = pwdata[15:0];
      end
   end

   always_ff @(posedge pclk) begin
      cmp_first_q  <= cmp_first_d;
      cmp_second_q <= cmp_second_d;
   end

   // count clock, output toggle and interrupts
   always_comb begin
      div_d = div_q + 6'h01;
      case (clk_sel_q)
         2'b00:   lnk.count_tick = ((div_q & DIV_MASK_2) == DIV_MASK_2);
         2'b01:   lnk.count_tick = ((div_q & DIV_MASK_8) == DIV_MASK_8);
         2'b10:   lnk.count_tick = ((div_q & DIV_MASK_64) == DIV_MASK_64);
         default: lnk.count_tick = lnk.valid_edge;
      endcase
      lnk.op_mode           = mode_q[BIT_OP_HI:BIT_OP_LO];
      lnk.edge_sel          = edge_sel_q;
      lnk.second_is_capture = sel_second_q;
      lnk.cmp_first         = cmp_first_q;
      lnk.cmp_second        = cmp_second_q;
      toggle = running & (lnk.match_first | lnk.match_second
               | (mode_q[BIT_OUT_TIMING] & lnk.valid_edge));
      tout_d = tout_q ^ toggle;
      events                   = '0;
      events[IRQ_MATCH_FIRST]  = lnk.match_first;
      events[IRQ_MATCH_SECOND] = lnk.match_second;
      events[IRQ_OVERFLOW]     = lnk.wrap;
      stat_d = stat_q;
      if (wr_byte && hit_stat) begin
         stat_d = stat_q & ~pwdata[IRQ_BITS-1:0];
      end
      stat_d  = stat_d | events;
      mirq1_d = lnk.match_first;
      mirq2_d = lnk.match_second;
      irq_d   = |(stat_d & mask_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q   <= 6'h00;
         tout_q  <= 1'b0;
         stat_q  <= RST_IRQ;
         mirq1_q <= 1'b0;
         mirq2_q <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         div_q   <= div_d;
         tout_q  <= tout_d;
         stat_q  <= stat_d;
         mirq1_q <= mirq1_d;
         mirq2_q <= mirq2_d;
         irq_q   <= irq_d;
      end
   end

   input_edge_detect u_edge (
      .pclk              (pclk),
      .presetn           (presetn),
      .timer_input_first (timer_input_first),
      .lnk               (lnk)
   );

   count_core u_core (
      .pclk    (pclk),
      .presetn (presetn),
      .lnk     (lnk)
   );

   assign pready           = pready_q;
   assign prdata           = prdata_q;
   assign pslverr          = pslverr_q;
   assign timer_output_pin = tout_q;
   assign match_irq_first  = mirq1_q;
   assign match_irq_second = mirq2_q;
   assign irq              = irq_q;
endmodule : timer_mode_and_capture_ctrl
`default_nettype wire

// file: sim/pin_source.sv
// partner model: external event source on the first timer input pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
   // clock
   input  wire logic pclk,
   // pin
   output var logic  timer_input_first
);
   logic toggle_on;
   logic level;
   initial begin
      timer_input_first = 1'b0;
      toggle_on = 1'b0;
      level = 1'b0;
   end
   // pin changes only just after a clock edge
   always @(posedge pclk) begin
      timer_input_first <= toggle_on ? !timer_input_first : level;
   end
   task automatic toggle(input logic on);
      @(posedge pclk);
      toggle_on <= on;
   endtask : toggle
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         level <= 1'b1;
         repeat (2) @(posedge pclk);
         level <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask : pulses
endmodule : pin_source
`default_nettype wire

// file: sim/timer_ctrl_chk.sv
// checker: port-level properties of the timer block
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_chk
   import timer_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // pins and interrupts
   input wire logic        timer_input_first,
   input wire logic        timer_output_pin,
   input wire logic        match_irq_first,
   input wire logic        match_irq_second,
   input wire logic        irq
);
   logic       wr_hit;
   logic       mapped;
   logic [1:0] op_q, op_d;
   logic       timing_q, timing_d;
   logic [2:0] mask_q, mask_d;
   logic [1:0] stop_q, stop_d;
   // shadow of mode and mask as written over apb
   always_comb begin
      wr_hit = psel && penable && pready && pwrite && pstrb[0];
      mapped = (paddr >= ADDR_MODE_CTRL) && (paddr <= ADDR_IRQ_MASK) && (paddr[1:0] == 2'h0);
      op_d = op_q;
      timing_d = timing_q;
      mask_d = mask_q;
      if (wr_hit && paddr == ADDR_MODE_CTRL) begin
         op_d = pwdata[BIT_OP_HI:BIT_OP_LO];
         timing_d = pwdata[BIT_OUT_TIMING];
      end
      if (wr_hit && paddr == ADDR_IRQ_MASK) begin
         mask_d = pwdata[2:0];
      end
      stop_d = (op_q != 2'h0) ? 2'h0 : ((stop_q == 2'h3) ? stop_q : stop_q + 2'h1);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= 2'h0;
         timing_q <= 1'b0;
         mask_q <= 3'h0;
         stop_q <= 2'h0;
      end else begin
         op_q <= op_d;
         timing_q <= timing_d;
         mask_q <= mask_d;
         stop_q <= stop_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait_state;
      psel && penable && !$past(penable) |-> !pready ##1 pready;
   endproperty
   a_wait_state: assert property (p_wait_state)
      else $error("pready not after one wait state");
   property p_ready_once;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("pready outside access or too long");
   property p_err_map;
      pready |-> pslverr == !mapped;
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("pslverr does not match address map");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("prdata nonzero without pready");
   property p_match_pulse;
      (match_irq_first |=> !match_irq_first) and (match_irq_second |=> !match_irq_second);
   endproperty
   a_match_pulse: assert property (p_match_pulse)
      else $error("match interrupt longer than one cycle");
   property p_stop_quiet;
      stop_q == 2'h3 |-> !match_irq_first && !match_irq_second && $stable(timer_output_pin);
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("activity while stopped");
   property p_irq_masked;
      (mask_q == 3'h0) [*2] |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("irq high with all sources masked");
   property p_out_toggle;
      match_irq_first && !timing_q |-> $changed(timer_output_pin) or ##1 $changed(timer_output_pin);
   endproperty
   a_out_toggle: assert property (p_out_toggle)
      else $error("output did not toggle on first match");
endmodule : timer_ctrl_chk
bind timer_mode_and_capture_ctrl timer_ctrl_chk u_timer_ctrl_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .timer_input_first(timer_input_first),
   .timer_output_pin(timer_output_pin), .match_irq_first(match_irq_first),
   .match_irq_second(match_irq_second), .irq(irq));
`default_nettype wire

// file: sim/testbench.sv
// testbench: apb-driven scenarios for the timer mode and capture block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import timer_pkg::*;
;
   localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
   localparam logic [1:0]  EDGES [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   localparam logic [15:0] CNTS [4] = '{16'h3, 16'h3, 16'h6, 16'h0};
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        timer_input_first;
   logic        timer_output_pin;
   logic        match_irq_first;
   logic        match_irq_second;
   logic        irq;
   logic [32:0] exp_q[$];
   logic [32:0] msk_q[$];
   int          err_total;
   int          checked;
   int          seed;
   logic [15:0] val;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   timer_mode_and_capture_ctrl u_timer_mode_and_capture_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .timer_input_first(timer_input_first),
      .timer_output_pin(timer_output_pin), .match_irq_first(match_irq_first),
      .match_irq_second(match_irq_second), .irq(irq));
   pin_source u_pin_source (.pclk(pclk), .timer_input_first(timer_input_first));
   task automatic cmp_read(input logic [32:0] got, input logic [32:0] e, input logic [32:0] m);
      checked++;
      if ((got & m) !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got & m, e);
      end
   endtask : cmp_read
   task automatic cmp_bit(input logic got, input logic e);
      checked++;
      if (got !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : cmp_bit
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   task automatic wait_pulse(input logic second, input int lim);
      int   n;
      logic v;
      n = 0;
      v = 1'b0;
      while (v !== 1'b1 && n < lim) begin
         @(posedge pclk);
         v = second ? match_irq_second : match_irq_first;
         n++;
      end
      cmp_bit(v, 1'b1);
   endtask : wait_pulse
   task automatic results();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Testbench passed");
      end
      else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // read monitor: oldest note against each completed read
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         cmp_read({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
      end
   end
   initial begin
      repeat (90000) @(posedge pclk);
      err_total++;
      results();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      err_total = 0;
      checked = 0;
      seed = 70;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_MODE_CTRL, 33'h0, ALL);
      rd(ADDR_CC_CTRL, 33'h0, ALL);
      rd(ADDR_COUNTER, 33'h0, ALL);
      rd(ADDR_IRQ_STAT, 33'h0, ALL);
      rd(16'hFF80, 33'h1_0000_0000, ALL);
      val = 16'($random(seed)) | 16'h0001;
      wr(ADDR_CMP_SECOND, {16'h0, val});
      apb(1'b1, ADDR_CMP_SECOND, 32'h0, 4'h1);
      rd(ADDR_CMP_SECOND, {17'h0, val}, ALL);
      apb(1'b1, ADDR_MODE_CTRL, 32'h4, 4'h0);
      rd(ADDR_MODE_CTRL, 33'h0, ALL);
      // fast free run through a full wrap, counting every pin edge
      wr(ADDR_PRESCALER, 32'h33);
      wr(ADDR_CMP_FIRST, 32'h10);
      wr(ADDR_CMP_SECOND, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h7);
      u_pin_source.toggle(1'b1);
      wr(ADDR_MODE_CTRL, 32'h4);
      wait_pulse(1'b0, 100);
      wait_pulse(1'b1, 70000);
      u_pin_source.toggle(1'b0);
      rd(ADDR_MODE_CTRL, 33'h5, ALL);
      rd(ADDR_IRQ_STAT, 33'h7, ALL);
      cmp_bit(irq, 1'b1);
      wr(ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      cmp_bit(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h7);
      wr(ADDR_MODE_CTRL, 32'h4);
      rd(ADDR_MODE_CTRL, 33'h4, ALL);
      wr(ADDR_MODE_CTRL, 32'h5);
      rd(ADDR_MODE_CTRL, 33'h4, ALL);
      wr(ADDR_IRQ_STAT, 32'h7);
      rd(ADDR_IRQ_STAT, 33'h0, ALL);
      cmp_bit(irq, 1'b0);
      wr(ADDR_MODE_CTRL, 32'h0);
      rd(ADDR_COUNTER, 33'h0, ALL);
      // capture and edge select, counting on pin edges
      wr(ADDR_CC_CTRL, 32'h4);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_MODE_CTRL, 32'h0);
         wr(ADDR_PRESCALER, {26'h0, EDGES[i], 4'h3});
         wr(ADDR_MODE_CTRL, 32'h4);
         u_pin_source.pulses(3);
         rd(ADDR_COUNTER, {17'h0, CNTS[i]}, ALL);
         if (i < 3) begin
            rd(ADDR_CMP_SECOND, {17'h0, CNTS[i] - 16'h1}, ALL);
         end
      end
      // clear on first compare match: period of four edges
      wr(ADDR_MODE_CTRL, 32'h0);
      wr(ADDR_CC_CTRL, 32'h0);
      wr(ADDR_CMP_FIRST, 32'h3);
      wr(ADDR_PRESCALER, 32'h13);
      wr(ADDR_MODE_CTRL, 32'hE);
      val[0] = timer_output_pin;
      u_pin_source.pulses(5);
      cmp_bit(timer_output_pin, val[0]);
      rd(ADDR_COUNTER, 33'h1, ALL);
      // clear on pin edge while counting the divided clock
      wr(ADDR_MODE_CTRL, 32'h0);
      wr(ADDR_PRESCALER, 32'h10);
      wr(ADDR_MODE_CTRL, 32'h8);
      repeat (40) @(posedge pclk);
      u_pin_source.pulses(1);
      rd(ADDR_COUNTER, 33'h0, 33'h1_FFFF_FFF8);
      wr(ADDR_MODE_CTRL, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_IRQ_MASK, 33'h0, ALL);
      results();
   end
endmodule : testbench
`default_nettype wire
